//--- inc/hfs_pkg.sv
package hfs_pkg;

  // time base
  localparam int CLK_PERIOD_NS = 25;
  localparam int TIMEOUT_PULSE_US = 64;
  localparam int TIMEOUT_PULSE_CYC =
    (TIMEOUT_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_TIME_US = 25;

  // serial frame layout
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] ADDR_DONE_FALLS = 5'h04;
  localparam logic [4:0] FALL_CNT_MAX = 5'h1F;
  localparam logic [3:0] RISE_CNT_MAX = 4'hF;
  localparam logic [3:0] DATA_FIRST_RISE = 4'h8;
  localparam logic [3:0] DATA_LAST_RISE = 4'hF;
  localparam int RW_BIT = 15;
  localparam int ADDR_LSB = 11;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register addresses
  localparam logic [3:0] ADDR_FAULT = 4'h0;
  localparam logic [3:0] ADDR_VDS_GDF = 4'h1;
  localparam logic [3:0] ADDR_MAIN = 4'h2;
  localparam logic [3:0] ADDR_DRIVE_WD = 4'h3;
  localparam logic [3:0] ADDR_VDS_CTL = 4'h4;
  localparam logic [3:0] ADDR_CONFIG = 4'h5;
  localparam int NUM_REGS = 6;

  // fault status bit positions
  localparam int FLT_SUM = 7;
  localparam int FLT_WD = 6;
  localparam int FLT_GDF = 5;
  localparam int FLT_OCP = 4;
  localparam int FLT_VMUV = 3;
  localparam int FLT_CPUV = 2;
  localparam int FLT_OVERTEMP_SHUTDOWN_FLAG = 1;
  localparam int FLT_OTW = 0;

  // control field positions
  localparam int MAIN_CLR_BIT = 0;
  localparam int HOST_TIMER_ENABLE_BIT_BIT = 5;
  localparam int HOST_TIMER_INTERVAL_FIELD_LSB = 3;
  localparam int CFG_TOFF_LSB = 6;
  localparam int CFG_CHOP_DIS_BIT = 5;
  localparam int CFG_VREF_SCL_BIT = 4;
  localparam int CFG_GAIN_LSB = 0;

  // reset values
  localparam logic [7:0] RST_MAIN = 8'h00;
  localparam logic [7:0] RST_DRIVE_WD = 8'h00;
  localparam logic [7:0] RST_VDS_CTL = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;

  // fixed settings of the pin-configured variant
  localparam logic [1:0] PIN_TOFF_CODE = 2'h1;
  localparam logic [1:0] PIN_GAIN_CODE = 2'h3;

  typedef struct packed {
    logic [3:0] vds_over;
    logic [3:0] gate_ok;
    logic [3:0] drive_cmd;
    logic shunt_over;
    logic die_overtemp;
    logic temp_recovered;
    logic temp_warn;
    logic supply_supply_undervoltage_lockout;
    logic sleep_n;
    logic [1:0] mode_sel;
  } hfs_sense_t;

  typedef struct packed {
    logic [1:0] toff_code;
    logic chop_en;
    logic vref_unscaled;
    logic [1:0] gain_code;
  } hfs_cfg_t;

  typedef struct packed {
    logic fets_en;
    logic charge_pump_en;
    logic analog_reg_en;
    logic digital_reg_en;
  } hfs_power_t;

  typedef enum logic [1:0] {
    HFS_AWAKE,
    HFS_ENTER,
    HFS_SLEEP,
    HFS_WAKE
  } hfs_sleep_t;

endpackage

//--- tb/hfs_host_model.sv
`timescale 1ns/1ps
module hfs_host_model (
  // serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  logic [7:0] rdat;
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    rdat = 8'h00;
  end
  // clock only runs inside a frame, low at both select edges
  task automatic xfer(input logic [15:0] w, input int n);
    int i;
    cs_n_o = 1'b0;
    rdat = 8'h00;
    for (i = 0; i < n; i++)
    begin
      // data moves with the rising edge, clear of the sampling edge
      #24 sclk_o = 1'b1;
      sdi_o = w[15 - (i % 16)]; // msb first
      #24 sclk_o = 1'b0;
      if (i >= 8 && i <= 15)
        rdat = {rdat[6:0], sdo_i};
    end
    #24 cs_n_o = 1'b1;
    // released line must not look held
    sdi_o = ~sdi_o;
    #600;
  endtask
endmodule // hfs_host_model

//--- tb/hfs_supervisor_tb_top.sv
`timescale 1ns/1ps
module hfs_supervisor_tb_top;
  import hfs_pkg::*;
  localparam int DG = 8;
  localparam int RT = 10;
  localparam int GC = 8;
  localparam int SL = 6;
  localparam int WK = 6;
  logic sys_clk, reset, sck, csn, sdi, sdo, sdo_oe;
  logic flt_oe, to_oe, asleep;
  logic [1:0] mode;
  hfs_sense_t s;
  hfs_power_t pw;
  hfs_cfg_t cfg;
  hfs_cfg_t cfg_pin;
  int fails, checks, cyc, n;
  hfs_supervisor #(.DEGLITCH_CYCLES(DG), .RETRY_CYCLES(RT),
    .GATE_CHECK_CYCLES(GC), .SLEEP_CYCLES(SL), .WAKE_CYCLES(WK),
    .WD_BASE_CYCLES(50)) u_hfs_supervisor (
    .sys_clk_i(sys_clk), .reset_i(reset), .serial_clk_i(sck),
    .chip_select_n_i(csn), .serial_data_i(sdi), .serial_data_o(sdo),
    .serial_data_oe_o(sdo_oe), .sense_i(s), .fault_indicator_pin_o(),
    .fault_indicator_pin_oe_o(flt_oe), .host_timeout_pin_o(),
    .host_timeout_pin_oe_o(to_oe), .power_o(pw), .cfg_o(cfg),
    .mode_o(mode), .asleep_o(asleep));
  hfs_supervisor #(.SERIAL_VARIANT(1'b0)) u_hfs_supervisor_pin (
    .sys_clk_i(sys_clk), .reset_i(reset), .serial_clk_i(1'b0),
    .chip_select_n_i(1'b1), .serial_data_i(1'b0), .serial_data_o(),
    .serial_data_oe_o(), .sense_i(s), .fault_indicator_pin_o(),
    .fault_indicator_pin_oe_o(), .host_timeout_pin_o(),
    .host_timeout_pin_oe_o(), .power_o(), .cfg_o(cfg_pin), .mode_o(),
    .asleep_o());
  hfs_host_model u_hfs_host_model (.sclk_o(sck), .cs_n_o(csn),
    .sdi_o(sdi), .sdo_i(sdo));
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task print_verdict;
    $display("errors %0d checks %0d", fails, checks);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // whole run needs about 5000 cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      print_verdict;
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stp(input int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_hfs_host_model.xfer({1'b0, a, 3'h0, d}, 16);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    u_hfs_host_model.xfer({1'b1, a, 11'h000}, 16);
    chk(u_hfs_host_model.rdat, e);
  endtask
  task automatic t_serial;
    wr(ADDR_CONFIG, 8'hC2);
    rd(ADDR_CONFIG, 8'hC2);
    chk({cfg.toff_code, cfg.gain_code}, 4'hE);
    u_hfs_host_model.xfer({1'b0, ADDR_CONFIG, 11'h011}, 15);
    u_hfs_host_model.xfer({1'b0, ADDR_CONFIG, 11'h011}, 17);
    rd(ADDR_CONFIG, 8'hC2);
  endtask
  task automatic t_ocp;
    s.shunt_over = 1'b1;
    stp(5);
    chk({pw.fets_en, flt_oe}, 2'h1);
    s.shunt_over = 1'b0;
    stp(RT + 8);
    chk({pw.fets_en, flt_oe}, 2'h2);
    rd(ADDR_FAULT, 8'h90);
    wr(ADDR_MAIN, 8'h01);
    rd(ADDR_FAULT, 8'h00);
    stp(1);
    s.drive_cmd = 4'h1;
    s.gate_ok = 4'h1;
    s.vds_over = 4'h1;
    stp(DG + 8);
    chk({pw.fets_en, flt_oe}, 2'h1);
    s.vds_over = 4'h0;
    stp(RT + 8);
    rd(ADDR_VDS_GDF, 8'h01);
    wr(ADDR_MAIN, 8'h01);
    stp(1);
    s.drive_cmd = 4'h3;
    stp(GC + 8);
    chk({pw.fets_en, flt_oe}, 2'h1);
    s.gate_ok = 4'h3;
    stp(RT + 8);
    chk({pw.fets_en, flt_oe}, 2'h2);
    rd(ADDR_FAULT, 8'hA0);
    rd(ADDR_VDS_GDF, 8'h20);
    wr(ADDR_MAIN, 8'h01);
  endtask
  task automatic t_thermal;
    stp(1);
    s.die_overtemp = 1'b1;
    stp(5);
    chk({pw, flt_oe}, 5'h03);
    s.die_overtemp = 1'b0;
    s.temp_recovered = 1'b1;
    stp(5);
    chk({pw, flt_oe}, 5'h1E);
    s.temp_warn = 1'b1;
    stp(4);
    rd(ADDR_FAULT, 8'h83);
    wr(ADDR_MAIN, 8'h01);
    rd(ADDR_FAULT, 8'h01);
  endtask
  task automatic t_timer;
    chk(to_oe, 1'b0);
    wr(ADDR_DRIVE_WD, 8'h38);
    repeat (4)
    begin
      stp(90);
      rd(ADDR_FAULT, 8'h01);
      chk(to_oe, 1'b0);
    end
    n = 0;
    while (!to_oe && n < 400)
    begin
      stp(1);
      n++;
    end
    n = 0;
    while (to_oe && n < 3000)
    begin
      chk({pw.fets_en, flt_oe}, 2'h1);
      stp(1);
      n++;
    end
    chk(n, TIMEOUT_PULSE_CYC);
    rd(ADDR_DRIVE_WD, 8'h18);
    rd(ADDR_FAULT, 8'hC1);
    chk({pw.fets_en, flt_oe}, 2'h1);
    wr(ADDR_MAIN, 8'h01);
    chk({pw.fets_en, flt_oe}, 2'h2);
  endtask
  task automatic t_sleep;
    wr(ADDR_CONFIG, 8'hC2);
    stp(1);
    s.mode_sel = 2'h1;
    s.sleep_n = 1'b0;
    stp(2);
    chk({asleep, mode}, 3'h2);
    stp(SL + 6);
    chk({asleep, pw}, 5'h10);
    s.sleep_n = 1'b1;
    stp(4);
    chk(pw.fets_en, 1'b0);
    stp(WK + 6);
    chk({pw, mode, cfg}, 12'hF4C);
  endtask
  initial
  begin
    reset = 1'b1;
    s = '0;
    s.sleep_n = 1'b1;
    s.mode_sel = 2'h2;
    repeat (12) @(posedge sys_clk);
    #2 reset = 1'b0;
    stp(6);
    chk({pw, flt_oe, to_oe, sdo_oe, mode}, 9'h1E2);
    chk(cfg_pin, 6'h1F);
    t_serial();
    t_ocp();
    t_thermal();
    t_timer();
    t_sleep();
    print_verdict;
  end
endmodule // hfs_supervisor_tb_top

//--- verilog/hfs_supervisor.sv
// Function
// RULE_01: vds overcurrent past deglitch shuts bridge down
// RULE_02: retry after interval; overcurrent flag sticky
// RULE_03: shunt overcurrent also trips overcurrent
// RULE_04: gate not switching in time is fault
// RULE_05: gate fault retries; its flag sticky
// RULE_06: overtemp kills bridge, pump, analog regulator
// RULE_07: overtemp auto-recovers; flag stays until cleared
// RULE_08: host timer off at reset, host enables
// RULE_09: host timer counts; reading address zero restarts
// RULE_10: timeout pulses pin 64us, stops drive
// RULE_11: timeout halts until clear bit written
// RULE_12: pin variant uses fixed drive settings
// RULE_13: sleep turns off pump, bridge, regulators
// RULE_14: sleep after entry delay; wake delay holds
// RULE_15: undervoltage exit or wake resets settings
// RULE_16: mode latched at power-up and wake
// RULE_17: 16-bit frame: command, ignored, data
// RULE_18: host uses mode 1, 16 clocks
// RULE_19: host keeps select high 500ns between
// RULE_20: select high ignores clock, output floats
// RULE_21: sample falling, drive rising, msb first
// RULE_22: write frame not 16 bits discarded
// RULE_23: bit 15 direction, 14:11 address, 7:0 data
// RULE_24: read returns addressed register in low byte
// RULE_25: summary bit ORs faults except warning
// RULE_26: timings are parameterised clock counters
`timescale 1ns/1ps
module hfs_supervisor #(
  parameter bit SERIAL_VARIANT = 1'b1,
  parameter int DEGLITCH_CYCLES = 160,
  parameter int RETRY_CYCLES = 120,
  parameter int GATE_CHECK_CYCLES = 160,
  parameter int SLEEP_CYCLES = 40,
  parameter int WAKE_CYCLES = 40,
  parameter int WD_BASE_CYCLES = 40000
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // serial link
  input wire logic serial_clk_i,
  input wire logic chip_select_n_i,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe_o,
  // analog sense and pins
  input wire hfs_pkg::hfs_sense_t sense_i,
  // open-drain pins
  output logic fault_indicator_pin_o,
  output logic fault_indicator_pin_oe_o,
  output logic host_timeout_pin_o,
  output logic host_timeout_pin_oe_o,
  // control outputs
  output hfs_pkg::hfs_power_t power_o,
  output hfs_pkg::hfs_cfg_t cfg_o,
  output logic [1:0] mode_o,
  output logic asleep_o
);
  import hfs_pkg::*;

  // input synchronisers
  hfs_sense_t sense_m;
  hfs_sense_t sense_s;
  logic cs_m;
  logic cs_s;
  logic cs_q;
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sense_m <= '0;
      sense_s <= '0;
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_q <= 1'b1;
    end
    else
    begin
      sense_m <= sense_i;
      sense_s <= sense_m;
      cs_m <= chip_select_n_i;
      cs_s <= cs_m;
      cs_q <= cs_s;
    end
  end

  // link side: shift in on falling edge
  logic [15:0] rx_word;
  logic [4:0] fall_cnt;
  logic fall_arm;
  logic rise_arm;
  logic [3:0] rise_cnt;
  logic [3:0] rd_addr;
  logic [7:0] rd_byte;
  logic [7:0] snap [NUM_REGS];
  logic frame_tgl;

  // select high re-arms the frame; clock and data are not looked at
  always_ff @(negedge serial_clk_i or posedge chip_select_n_i)
  begin
    if (chip_select_n_i)
      fall_arm <= 1'b1; // [RULE_20]
    else
      fall_arm <= 1'b0;
  end

  always_ff @(negedge serial_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rx_word <= '0;
      fall_cnt <= '0;
      rd_addr <= '0;
      frame_tgl <= 1'b0;
    end
    else if (!chip_select_n_i)
    begin
      // flips once per clocked frame, so an empty select pulse counts nothing
      if (fall_arm)
        frame_tgl <= ~frame_tgl; // [RULE_22]
      rx_word <= {rx_word[14:0], serial_data_i}; // [RULE_21]
      if (fall_arm)
        fall_cnt <= 5'h01;
      else if (fall_cnt != FALL_CNT_MAX)
        fall_cnt <= fall_cnt + 5'h01; // [RULE_22]
      if (!fall_arm && fall_cnt == ADDR_DONE_FALLS)
        rd_addr <= {rx_word[2:0], serial_data_i}; // [RULE_23]
    end
  end

  always_ff @(posedge serial_clk_i or posedge chip_select_n_i)
  begin
    if (chip_select_n_i)
      rise_arm <= 1'b1;
    else
      rise_arm <= 1'b0;
  end

  // snapshot is frozen during a frame, so it is stable here
  assign rd_byte = (rd_addr < 4'(NUM_REGS)) ? snap[rd_addr[2:0]] : 8'h00;

  always_ff @(posedge serial_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rise_cnt <= '0;
      serial_data_o <= 1'b0;
    end
    else
    begin
      if (rise_arm)
        rise_cnt <= 4'h1;
      else if (rise_cnt != RISE_CNT_MAX)
        rise_cnt <= rise_cnt + 4'h1;
      // upper byte is filler, low byte msb first [RULE_17] [RULE_24]
      if (!rise_arm && rise_cnt >= DATA_FIRST_RISE &&
          rise_cnt <= DATA_LAST_RISE)
        serial_data_o <= rd_byte[3'(DATA_LAST_RISE - rise_cnt)]; // [RULE_21]
      else
        serial_data_o <= 1'b0;
    end
  end

  assign serial_data_oe_o = ~chip_select_n_i; // [RULE_20]

  // frame hand-off; link clock is idle once select is high
  logic frame_done;
  logic frame_ok;
  logic is_read;
  logic [3:0] f_addr;
  logic [7:0] f_data;
  logic wr_ok;
  logic rd_kick;
  logic clr_pulse;
  assign frame_done = cs_s & ~cs_q;
  logic seen_tgl;
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      seen_tgl <= 1'b0;
    else if (frame_done)
      seen_tgl <= frame_tgl;
  end
  assign frame_ok = (fall_cnt == FRAME_BITS) & (frame_tgl != seen_tgl);
  assign is_read = rx_word[RW_BIT];
  assign f_addr = rx_word[ADDR_LSB +: ADDR_W];
  assign f_data = rx_word[DATA_W-1:0];
  assign wr_ok = frame_done & frame_ok & ~is_read; // [RULE_22]
  assign rd_kick = frame_done & frame_ok & is_read &
                   (f_addr == ADDR_FAULT); // [RULE_09]
  assign clr_pulse = wr_ok & (f_addr == ADDR_MAIN) & f_data[MAIN_CLR_BIT];

  // sleep and supply tracking
  hfs_sleep_t state;
  logic [15:0] slp_cnt;
  logic sleep_n_q;
  logic supply_undervoltage_lockout_q;
  logic sleep_exit;
  logic uv_exit;
  logic soft_clr;
  assign sleep_exit = (state == HFS_SLEEP) & sense_s.sleep_n;
  assign uv_exit = supply_undervoltage_lockout_q & ~sense_s.supply_supply_undervoltage_lockout;
  assign soft_clr = sleep_exit | uv_exit; // [RULE_15]

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state <= HFS_AWAKE;
      slp_cnt <= '0;
      sleep_n_q <= 1'b1;
      supply_undervoltage_lockout_q <= 1'b0;
    end
    else
    begin
      sleep_n_q <= sense_s.sleep_n;
      supply_undervoltage_lockout_q <= sense_s.supply_supply_undervoltage_lockout;
      slp_cnt <= slp_cnt + 16'h1;
      case (state)
        HFS_AWAKE:
          if (sleep_n_q && !sense_s.sleep_n)
          begin
            state <= HFS_ENTER;
            slp_cnt <= '0;
          end
        HFS_ENTER:
          if (sense_s.sleep_n)
            state <= HFS_AWAKE;
          else if (slp_cnt == 16'(SLEEP_CYCLES - 1))
            state <= HFS_SLEEP; // [RULE_14]
        HFS_SLEEP:
          if (sense_s.sleep_n)
          begin
            state <= HFS_WAKE; // [RULE_14]
            slp_cnt <= '0;
          end
        HFS_WAKE:
          if (slp_cnt == 16'(WAKE_CYCLES - 1))
            state <= HFS_AWAKE; // [RULE_14]
        default:
          state <= HFS_AWAKE;
      endcase
    end
  end

  // control mode latch
  // waits out the synchroniser so the pin, not its reset value, is latched
  logic mode_req;
  logic [1:0] boot_q;
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mode_req <= 1'b1;
      boot_q <= '0;
      mode_o <= '0;
    end
    else
    begin
      boot_q <= {boot_q[0], 1'b1};
      if (boot_q[1])
        mode_req <= 1'b0;
      if ((mode_req && boot_q[1]) || sleep_exit)
        mode_o <= sense_s.mode_sel; // [RULE_16]
    end
  end

  // host-written settings
  logic [7:0] main_reg;
  logic [7:0] drive_wd_reg;
  logic [7:0] vds_reg;
  logic [7:0] cfg_reg;
  logic wd_expire;
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      main_reg <= RST_MAIN;
      drive_wd_reg <= RST_DRIVE_WD; // [RULE_08]
      vds_reg <= RST_VDS_CTL;
      cfg_reg <= RST_CONFIG;
    end
    else if (soft_clr)
    begin
      main_reg <= RST_MAIN; // [RULE_15]
      drive_wd_reg <= RST_DRIVE_WD;
      vds_reg <= RST_VDS_CTL;
      cfg_reg <= RST_CONFIG;
    end
    else
    begin
      if (wr_ok)
      begin
        case (f_addr)
          ADDR_MAIN: main_reg <= f_data & ~8'(1 << MAIN_CLR_BIT);
          ADDR_DRIVE_WD: drive_wd_reg <= f_data; // [RULE_08]
          ADDR_VDS_CTL: vds_reg <= f_data;
          ADDR_CONFIG: cfg_reg <= f_data;
          default: ;
        endcase
      end
      if (wd_expire)
        drive_wd_reg[HOST_TIMER_ENABLE_BIT_BIT] <= 1'b0; // [RULE_10]
    end
  end

  // per-fet overcurrent deglitch and gate check
  logic [3:0] vds_evt;
  logic [3:0] gdf_evt;
  for (genvar i = 0; i < 4; i++)
  begin : g_fet
    logic [15:0] dg_cnt;
    logic [15:0] gc_cnt;
    logic gc_run;
    logic cmd_q;
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
      if (reset_i)
      begin
        dg_cnt <= '0;
        gc_cnt <= '0;
        gc_run <= 1'b0;
        cmd_q <= 1'b0;
      end
      else
      begin
        cmd_q <= sense_s.drive_cmd[i];
        if (power_o.fets_en && sense_s.drive_cmd[i] && sense_s.vds_over[i]
            && !vds_evt[i])
          dg_cnt <= dg_cnt + 16'h1; // [RULE_26]
        else
          dg_cnt <= '0;
        if (!power_o.fets_en || gdf_evt[i] ||
            sense_s.gate_ok[i] == sense_s.drive_cmd[i])
          gc_run <= 1'b0;
        if (power_o.fets_en && cmd_q != sense_s.drive_cmd[i])
        begin
          gc_run <= 1'b1;
          gc_cnt <= '0;
        end
        else
          gc_cnt <= gc_cnt + 16'h1; // [RULE_26]
      end
    end
    assign vds_evt[i] = dg_cnt == 16'(DEGLITCH_CYCLES); // [RULE_01]
    assign gdf_evt[i] = gc_run && gc_cnt == 16'(GATE_CHECK_CYCLES) &&
                        sense_s.gate_ok[i] != sense_s.drive_cmd[i]; // [RULE_04]
  end

  logic ocp_evt;
  logic gdf_any;
  assign ocp_evt = (|vds_evt) |
                   (sense_s.shunt_over & power_o.fets_en); // [RULE_03]
  assign gdf_any = |gdf_evt;

  // retry timer shared by overcurrent and gate faults
  logic retry_active;
  logic [15:0] retry_cnt;
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      retry_active <= 1'b0;
      retry_cnt <= '0;
    end
    else if (ocp_evt || gdf_any)
    begin
      retry_active <= 1'b1; // [RULE_01] [RULE_04]
      retry_cnt <= '0;
    end
    else if (retry_active)
    begin
      retry_cnt <= retry_cnt + 16'h1;
      if (retry_cnt == 16'(RETRY_CYCLES - 1))
        retry_active <= 1'b0; // [RULE_02] [RULE_05]
    end
  end

  // thermal shutdown with hysteresis from the sensor
  logic tsd_active;
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      tsd_active <= 1'b0;
    else if (sense_s.die_overtemp)
      tsd_active <= 1'b1; // [RULE_06]
    else if (sense_s.temp_recovered)
      tsd_active <= 1'b0; // [RULE_07]
  end

  // host timer
  logic [31:0] wd_cnt;
  logic [31:0] wd_limit;
  logic wd_flag;
  logic [11:0] pulse_cnt;
  logic [11:0] next_pulse_cnt;
  assign wd_limit = 32'(WD_BASE_CYCLES) *
                    (32'(drive_wd_reg[HOST_TIMER_INTERVAL_FIELD_LSB +: 2]) + 32'h1);
  assign wd_expire = drive_wd_reg[HOST_TIMER_ENABLE_BIT_BIT] & ~rd_kick &
                     (wd_cnt == wd_limit - 32'h1); // [RULE_10]
  assign next_pulse_cnt = wd_expire ? 12'(TIMEOUT_PULSE_CYC) :
                          (pulse_cnt != 12'h0) ? pulse_cnt - 12'h1 : 12'h0;

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wd_cnt <= '0;
      pulse_cnt <= '0;
      host_timeout_pin_oe_o <= 1'b0;
    end
    else
    begin
      if (!drive_wd_reg[HOST_TIMER_ENABLE_BIT_BIT] || rd_kick || wd_expire)
        wd_cnt <= '0; // [RULE_08] [RULE_09]
      else
        wd_cnt <= wd_cnt + 32'h1;
      pulse_cnt <= next_pulse_cnt;
      host_timeout_pin_oe_o <= next_pulse_cnt != 12'h0; // [RULE_10]
    end
  end
  assign host_timeout_pin_o = 1'b0;

  // sticky status; a set in the clearing cycle wins
  logic ocp_flag;
  logic gdf_flag;
  logic overtemp_shutdown_flag_flag;
  logic otw_flag;
  logic vmuv_flag;
  logic [3:0] vds_flags;
  logic [3:0] gdf_flags;
  logic [7:0] fault_reg;
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ocp_flag <= 1'b0;
      gdf_flag <= 1'b0;
      overtemp_shutdown_flag_flag <= 1'b0;
      otw_flag <= 1'b0;
      vmuv_flag <= 1'b0;
      wd_flag <= 1'b0;
      vds_flags <= '0;
      gdf_flags <= '0;
    end
    else
    begin
      ocp_flag <= ocp_evt | (ocp_flag & ~clr_pulse); // [RULE_02]
      gdf_flag <= gdf_any | (gdf_flag & ~clr_pulse); // [RULE_05]
      overtemp_shutdown_flag_flag <= sense_s.die_overtemp | (overtemp_shutdown_flag_flag & ~clr_pulse); // [RULE_07]
      otw_flag <= sense_s.temp_warn | (otw_flag & ~clr_pulse);
      vmuv_flag <= sense_s.supply_supply_undervoltage_lockout | (vmuv_flag & ~clr_pulse);
      wd_flag <= wd_expire | (wd_flag & ~clr_pulse); // [RULE_11]
      vds_flags <= vds_evt | (vds_flags & ~{4{clr_pulse}});
      gdf_flags <= gdf_evt | (gdf_flags & ~{4{clr_pulse}});
    end
  end

  always_comb
  begin
    fault_reg = '0;
    fault_reg[FLT_WD] = wd_flag;
    fault_reg[FLT_GDF] = gdf_flag;
    fault_reg[FLT_OCP] = ocp_flag;
    fault_reg[FLT_VMUV] = vmuv_flag;
    fault_reg[FLT_CPUV] = 1'b0;
    fault_reg[FLT_OVERTEMP_SHUTDOWN_FLAG] = overtemp_shutdown_flag_flag;
    fault_reg[FLT_OTW] = otw_flag;
    fault_reg[FLT_SUM] = |fault_reg[FLT_WD:FLT_OVERTEMP_SHUTDOWN_FLAG]; // [RULE_25]
  end

  // register snapshot for the link, refreshed only between frames
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      snap <= '{default: 8'h00};
    else if (cs_s)
    begin
      snap[ADDR_FAULT[2:0]] <= fault_reg; // [RULE_24]
      snap[ADDR_VDS_GDF[2:0]] <= {gdf_flags, vds_flags};
      snap[ADDR_MAIN[2:0]] <= main_reg;
      snap[ADDR_DRIVE_WD[2:0]] <= drive_wd_reg;
      snap[ADDR_VDS_CTL[2:0]] <= vds_reg;
      snap[ADDR_CONFIG[2:0]] <= cfg_reg;
    end
  end

  // drive, supplies and fault indicator
  logic drive_block;
  logic in_sleep;
  assign in_sleep = (state == HFS_SLEEP);
  assign drive_block = retry_active | tsd_active | wd_flag | ocp_evt |
                       gdf_any | wd_expire | sense_s.supply_supply_undervoltage_lockout |
                       in_sleep | (state == HFS_WAKE);
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      power_o <= '0;
      fault_indicator_pin_oe_o <= 1'b0;
      asleep_o <= 1'b0;
    end
    else
    begin
      power_o.fets_en <= ~drive_block; // [RULE_01] [RULE_04] [RULE_10] [RULE_13]
      power_o.charge_pump_en <= ~(tsd_active | sense_s.die_overtemp |
                                  in_sleep); // [RULE_06] [RULE_13]
      power_o.analog_reg_en <= ~(tsd_active | sense_s.die_overtemp |
                                 in_sleep); // [RULE_06] [RULE_13]
      power_o.digital_reg_en <= ~in_sleep; // [RULE_13]
      fault_indicator_pin_oe_o <= retry_active | tsd_active | wd_flag |
                                  ocp_evt | gdf_any | wd_expire |
                                  sense_s.die_overtemp |
                                  sense_s.supply_supply_undervoltage_lockout; // [RULE_02] [RULE_07]
      asleep_o <= in_sleep;
    end
  end
  assign fault_indicator_pin_o = 1'b0;

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      cfg_o <= '0;
    else if (SERIAL_VARIANT)
    begin
      cfg_o.toff_code <= cfg_reg[CFG_TOFF_LSB +: 2];
      cfg_o.chop_en <= ~cfg_reg[CFG_CHOP_DIS_BIT];
      cfg_o.vref_unscaled <= ~cfg_reg[CFG_VREF_SCL_BIT];
      cfg_o.gain_code <= cfg_reg[CFG_GAIN_LSB +: 2];
    end
    else
    begin
      cfg_o.toff_code <= PIN_TOFF_CODE; // [RULE_12]
      cfg_o.chop_en <= 1'b1;
      cfg_o.vref_unscaled <= 1'b1;
      cfg_o.gain_code <= PIN_GAIN_CODE;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_timeout_act;
    ##1 (host_timeout_pin_oe_o && !power_o.fets_en &&
         !drive_wd_reg[HOST_TIMER_ENABLE_BIT_BIT] && fault_indicator_pin_oe_o);
  endsequence

  chk_ocp_shutdown: assert property ( // [RULE_01]
    ocp_evt |=> !power_o.fets_en && fault_indicator_pin_oe_o && ocp_flag)
    else $error("overcurrent did not shut down");
  chk_retry_release: assert property ( // [RULE_02]
    $fell(retry_active) |-> $past(retry_cnt) == 16'(RETRY_CYCLES - 1))
    else $error("retry released at wrong count");
  chk_shunt_trip: assert property ( // [RULE_03]
    (sense_s.shunt_over && power_o.fets_en) |=> ocp_flag && retry_active)
    else $error("shunt overcurrent not flagged");
  chk_gate_fault: assert property ( // [RULE_04]
    gdf_any |=> gdf_flag && !power_o.fets_en)
    else $error("gate fault not handled");
  chk_tsd_off: assert property ( // [RULE_06]
    tsd_active |=> !power_o.charge_pump_en && !power_o.analog_reg_en &&
                   !power_o.fets_en)
    else $error("thermal shutdown left supplies on");
  chk_wd_idle: assert property ( // [RULE_08]
    !drive_wd_reg[HOST_TIMER_ENABLE_BIT_BIT] |=> wd_cnt == 32'h0)
    else $error("host timer ran while disabled");
  chk_wd_kick: assert property ( // [RULE_09]
    (rd_kick && drive_wd_reg[HOST_TIMER_ENABLE_BIT_BIT]) |=> wd_cnt == 32'h0)
    else $error("read of address zero did not restart timer");
  chk_wd_pulse: assert property ( // [RULE_10]
    wd_expire |-> s_timeout_act)
    else $error("timeout actions missing");
  chk_wd_halt: assert property ( // [RULE_11]
    (wd_flag && !clr_pulse) |=> wd_flag && !power_o.fets_en)
    else $error("halt released without clear");
  chk_sleep_off: assert property ( // [RULE_13]
    in_sleep |=> !power_o.fets_en && !power_o.charge_pump_en &&
                 !power_o.digital_reg_en)
    else $error("sleep left outputs on");
  chk_frame_discard: assert property ( // [RULE_22]
    (frame_done && !frame_ok && !soft_clr && !wd_expire) |=>
      $stable(drive_wd_reg) && $stable(cfg_reg) && $stable(vds_reg))
    else $error("bad frame changed a register");

endmodule // hfs_supervisor
